/* File: src/lp_seq_consts.vh */
/*
 Constants for the low-power command timing sequencer: clock period,
 minimum times in picoseconds, minimum counts in clocks, cycle counts
 derived from both, and the request operation codes.
 Assumes the user clock is also the memory command clock at 50 MHz.
*/
// Summary of operation
// - Hold each CKE high and low level at least max(7.5 ns, 4 clocks).
// - After any command wait max(1.75 ns, 3 clocks) before CKE falls.
// - Keep the clock running max(5 ns, 5 clocks) after CKE falls.
// - CS valid 1.75 ns before CKE falls and max(5 ns, 5 clocks) after.
// - Run a valid clock max(1.75 ns, 3 clocks) before CKE rises.
// - No command until max(7.5 ns, 5 clocks) after power-down exit.
// - CS valid 1.75 ns before CKE rises and max(7.5 ns, 5 clocks) after.
// - After a mode write, clock and CS stay max(14 ns, 10 clocks).
// - After calibration start, clock and CS stay max(1.75 ns, 3 clocks).
// - Mode read waits row-to-column delay plus 3 clocks beyond exit delay.
// - Mode reads are spaced at least 8 clocks apart.
// - Mode writes are spaced at least max(10 ns, 10 clocks) apart.
// - After a mode set wait max(14 ns, 10 clocks) before next command.
// - After self-refresh entry wait max(1.75 ns, 3 clocks) before CKE low.
// - Stay in self-refresh at least max(15 ns, 3 clocks).
// - After self-refresh exit wait max(refresh cycle + 7.5 ns, 2 clocks).
// - Space training commands by 20 ns rounded up to whole clocks.
// - Hold strobe valid 10 ns before CKE falls for training.
// - First training command at least 250 ns after CKE falls.
// - Clock valid 2 clocks plus exit delay before, 5 clocks after exit.
`ifndef LP_SEQ_CONSTS_VH
`define LP_SEQ_CONSTS_VH

`define CLK_PERIOD_PS   20000
`define CNT_W           8

`define MAXC(a, b)      (((a) > (b)) ? (a) : (b))
`define PS2CK(t)        (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define T_CKE_PS        7500
`define N_CKE           4
`define T_CMDCKE_PS     1750
`define N_CMDCKE        3
`define T_CKELCK_PS     5000
`define N_CKELCK        5
`define T_CKCKEH_PS     1750
`define N_CKCKEH        3
`define T_CSCKEH_PS     1750
`define T_XP_PS         7500
`define N_XP            5
`define T_CKEHCS_PS     7500
`define N_CKEHCS        5
`define T_MRWCKEL_PS    14000
`define N_MRWCKEL       10
`define T_ZQCKE_PS      1750
`define N_ZQCKE         3
`define N_MRRI          3
`define N_MRR           8
`define T_MRW_PS        10000
`define N_MRW           10
`define T_MRD_PS        14000
`define N_MRD           10
`define T_ESCKE_PS      1750
`define N_ESCKE         3
`define T_SR_PS         15000
`define N_SR            3
`define T_XSR_ADD_PS    7500
`define N_XSR           2
`define T_ADR_PS        20000
`define T_DQSCKE_PS     10000
`define T_CAENT_PS      250000
`define T_VREF_SHORT_PS 80000
`define T_VREF_LONG_PS  250000
`define N_CKPRECS       2
`define T_CKPSTCS_PS    7500
`define N_CKPSTCS       5

`define C_CKE      `MAXC(`PS2CK(`T_CKE_PS), `N_CKE)
`define C_CMDCKE   `MAXC(`PS2CK(`T_CMDCKE_PS), `N_CMDCKE)
`define C_CKELCK   `MAXC(`PS2CK(`T_CKELCK_PS), `N_CKELCK)
`define C_CKCKEH   `MAXC(`PS2CK(`T_CKCKEH_PS), `N_CKCKEH)
`define C_CSCKEH   `PS2CK(`T_CSCKEH_PS)
`define C_XP       `MAXC(`PS2CK(`T_XP_PS), `N_XP)
`define C_CKEHCS   `MAXC(`PS2CK(`T_CKEHCS_PS), `N_CKEHCS)
`define C_MRWCKEL  `MAXC(`PS2CK(`T_MRWCKEL_PS), `N_MRWCKEL)
`define C_ZQCKE    `MAXC(`PS2CK(`T_ZQCKE_PS), `N_ZQCKE)
`define C_MRW      `MAXC(`PS2CK(`T_MRW_PS), `N_MRW)
`define C_MRD      `MAXC(`PS2CK(`T_MRD_PS), `N_MRD)
`define C_ESCKE    `MAXC(`PS2CK(`T_ESCKE_PS), `N_ESCKE)
`define C_SR       `MAXC(`PS2CK(`T_SR_PS), `N_SR)
`define C_CACD     `PS2CK(`T_ADR_PS)
`define C_DQSCKE   `PS2CK(`T_DQSCKE_PS)
`define C_CAENT    `PS2CK(`T_CAENT_PS)
`define C_VSHORT   `PS2CK(`T_VREF_SHORT_PS)
`define C_VLONG    `PS2CK(`T_VREF_LONG_PS)
`define C_CKPRECS  (`N_CKPRECS + `C_XP)
`define C_CKPSTCS  `MAXC(`PS2CK(`T_CKPSTCS_PS), `N_CKPSTCS)

`define OP_CMD   4'h0
`define OP_MRR   4'h1
`define OP_MRW   4'h2
`define OP_ZQ    4'h3
`define OP_PDE   4'h4
`define OP_PDX   4'h5
`define OP_SRE   4'h6
`define OP_SRX   4'h7
`define OP_CBTE  4'h8
`define OP_CBTC  4'h9
`define OP_VREF  4'hA
`define OP_CBTX  4'hB

`endif

/* File: src/lp_cmd_sequencer.v */
/*
 Host-side sequencer for low-power DRAM command spacing: drives clock
 enable, clock run enable, chip-select validity and training strobe, and
 issues commands only when the gap counter, and for mode reads also the read counter, has run out.
 Assumes requests come from logic on mclk_i, the device is already
 initialised when reset is released, and the PHY turns cmd_valid_o and
 cmd_code_o into the actual command bus encoding.
*/
`default_nettype none
`include "lp_seq_consts.vh"

module lp_cmd_sequencer #(
   parameter integer T_RCD_PS   = 18000,
   parameter integer T_RFCAB_PS = 180000
) (
   input  wire       mclk_i,
   input  wire       rstn_i,
   input  wire       req_i,
   input  wire [3:0] req_op_i,
   input  wire       req_multi_i,
   output reg        ack_o,
   output reg        err_o,
   output reg        cke_o,
   output reg        ck_en_o,
   output reg        cs_valid_o,
   output reg        strobe_o,
   output reg        cmd_valid_o,
   output reg  [3:0] cmd_code_o,
   output reg  [2:0] state_o
);

   localparam integer CW = `CNT_W;

   localparam [2:0] ST_ACT  = 3'h0;
   localparam [2:0] ST_FALL = 3'h1;
   localparam [2:0] ST_HOLD = 3'h2;
   localparam [2:0] ST_LOW  = 3'h3;
   localparam [2:0] ST_WAKE = 3'h4;
   localparam [2:0] ST_CBT  = 3'h5;
   localparam [2:0] ST_CBTX = 3'h6;

   localparam [1:0] TGT_PD  = 2'h0;
   localparam [1:0] TGT_SR  = 2'h1;
   localparam [1:0] TGT_CBT = 2'h2;

   // Counter loads are one below the span: decision cycles then differ
   // by exactly the span, and so do the registered pin edges.
   localparam integer CKE_I   = `C_CKE - 1;
   localparam integer CMDK_I  = `C_CMDCKE - 1;
   localparam integer ESCK_I  = `C_ESCKE - 1;
   localparam integer HLD_I   = `C_CKELCK - 1;
   localparam integer HMRW_I  = `MAXC(`C_MRWCKEL, `C_CKELCK) - 1;
   localparam integer HZQ_I   = `MAXC(`C_ZQCKE, `C_CKELCK) - 1;
   localparam integer WAKE_I  = `MAXC(`C_CKCKEH, `C_CSCKEH) - 1;
   localparam integer XP_I    = `MAXC(`C_XP, `C_CKEHCS) - 1;
   localparam integer MRRI_I  = `C_XP + `PS2CK(T_RCD_PS) + `N_MRRI - 1;
   localparam integer XSR_I   =
      `MAXC(`PS2CK(T_RFCAB_PS + `T_XSR_ADD_PS), `N_XSR) - 1;
   localparam integer MRR_I   = `N_MRR - 1;
   localparam integer MRW_I   = `MAXC(`C_MRW, `C_MRD) - 1;
   localparam integer SR_I    = `C_SR - 1;
   localparam integer CACD_I  = `C_CACD - 1;
   localparam integer DQS_I   = `C_DQSCKE - 1;
   localparam integer CAENT_I = `C_CAENT - 1;
   localparam integer VSH_I   = `C_VSHORT - 1;
   localparam integer VLG_I   = `C_VLONG - 1;
   localparam integer PRECS_I = `C_CKPRECS - 1;
   localparam integer PSTCS_I = `MAXC(`C_CKPSTCS, `C_XP) - 1;

   // Cut to counter width; every load is far below 2**CW
   localparam [CW-1:0] LD_CKE   = CKE_I[CW-1:0];
   localparam [CW-1:0] LD_CMDK  = CMDK_I[CW-1:0];
   localparam [CW-1:0] LD_ESCK  = ESCK_I[CW-1:0];
   localparam [CW-1:0] LD_HLD   = HLD_I[CW-1:0];
   localparam [CW-1:0] LD_HMRW  = HMRW_I[CW-1:0];
   localparam [CW-1:0] LD_HZQ   = HZQ_I[CW-1:0];
   localparam [CW-1:0] LD_WAKE  = WAKE_I[CW-1:0];
   localparam [CW-1:0] LD_XP    = XP_I[CW-1:0];
   localparam [CW-1:0] LD_MRRI  = MRRI_I[CW-1:0];
   localparam [CW-1:0] LD_XSR   = XSR_I[CW-1:0];
   localparam [CW-1:0] LD_MRR   = MRR_I[CW-1:0];
   localparam [CW-1:0] LD_MRW   = MRW_I[CW-1:0];
   localparam [CW-1:0] LD_SR    = SR_I[CW-1:0];
   localparam [CW-1:0] LD_CACD  = CACD_I[CW-1:0];
   localparam [CW-1:0] LD_DQS   = DQS_I[CW-1:0];
   localparam [CW-1:0] LD_CAENT = CAENT_I[CW-1:0];
   localparam [CW-1:0] LD_VSH   = VSH_I[CW-1:0];
   localparam [CW-1:0] LD_VLG   = VLG_I[CW-1:0];
   localparam [CW-1:0] LD_PRECS = PRECS_I[CW-1:0];
   localparam [CW-1:0] LD_PSTCS = PSTCS_I[CW-1:0];

   localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};

   // Eight down-counters shared among the spacing limits; zero opens the gate
   reg  [1:0]    target_r;
   reg  [3:0]    last_op_r;
   reg  [CW-1:0] cke_cnt_r;
   reg  [CW-1:0] ckel_cnt_r;
   reg  [CW-1:0] hold_cnt_r;
   reg  [CW-1:0] gap_cnt_r;
   reg  [CW-1:0] mrr_cnt_r;
   reg  [CW-1:0] sr_cnt_r;
   reg  [CW-1:0] pre_cnt_r;
   reg  [CW-1:0] str_cnt_r;

   // A held request is taken once: the cycle that shows ack is skipped.
   wire          take;
   wire          cke_ok;
   wire          gap_ok;

   assign take   = req_i & ~ack_o;
   assign cke_ok = (cke_cnt_r == CNT_ZERO);
   assign gap_ok = (gap_cnt_r == CNT_ZERO);

   // Counters park at zero so an idle gate never wraps shut
   function [CW-1:0] dec;
      input [CW-1:0] v;
      begin
         dec = (v == CNT_ZERO) ? v : v - 1'b1;
      end
   endfunction

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_o     <= ST_ACT;
         target_r    <= TGT_PD;
         last_op_r   <= `OP_CMD;
         ack_o       <= 1'b0;
         err_o       <= 1'b0;
         cke_o       <= 1'b1;
         ck_en_o     <= 1'b1;
         cs_valid_o  <= 1'b1;
         strobe_o    <= 1'b0;
         cmd_valid_o <= 1'b0;
         cmd_code_o  <= `OP_CMD;
         cke_cnt_r   <= LD_CKE;
         ckel_cnt_r  <= CNT_ZERO;
         hold_cnt_r  <= CNT_ZERO;
         gap_cnt_r   <= CNT_ZERO;
         mrr_cnt_r   <= CNT_ZERO;
         sr_cnt_r    <= CNT_ZERO;
         pre_cnt_r   <= CNT_ZERO;
         str_cnt_r   <= CNT_ZERO;
      end else begin
         ack_o       <= 1'b0;
         err_o       <= 1'b0;
         cmd_valid_o <= 1'b0;
         cke_cnt_r   <= dec(cke_cnt_r);
         ckel_cnt_r  <= dec(ckel_cnt_r);
         hold_cnt_r  <= dec(hold_cnt_r);
         gap_cnt_r   <= dec(gap_cnt_r);
         mrr_cnt_r   <= dec(mrr_cnt_r);
         sr_cnt_r    <= dec(sr_cnt_r);
         pre_cnt_r   <= dec(pre_cnt_r);
         str_cnt_r   <= dec(str_cnt_r);

         case (state_o)
            ST_ACT: begin
               if (take) begin
                  case (req_op_i)
                     `OP_CMD, `OP_ZQ, `OP_MRW, `OP_SRE: begin
                        if (gap_ok) begin
                           ack_o       <= 1'b1;
                           cmd_valid_o <= 1'b1;
                           cmd_code_o  <= req_op_i;
                           last_op_r   <= req_op_i;
                           // Self-refresh entry has its own CKE delay
                           if (req_op_i == `OP_SRE) begin
                              ckel_cnt_r <= LD_ESCK;
                              target_r   <= TGT_SR;
                              state_o    <= ST_FALL;
                           end else begin
                              ckel_cnt_r <= LD_CMDK;
                           end
                           if (req_op_i == `OP_MRW) begin
                              gap_cnt_r <= LD_MRW;
                           end
                        end
                     end

                     `OP_MRR: begin
                        if (gap_ok && mrr_cnt_r == CNT_ZERO) begin
                           ack_o       <= 1'b1;
                           cmd_valid_o <= 1'b1;
                           cmd_code_o  <= req_op_i;
                           last_op_r   <= req_op_i;
                           ckel_cnt_r  <= LD_CMDK;
                           mrr_cnt_r   <= LD_MRR;
                        end
                     end

                     `OP_PDE: begin
                        ack_o    <= 1'b1;
                        target_r <= TGT_PD;
                        state_o  <= ST_FALL;
                     end

                     `OP_CBTE: begin
                        ack_o     <= 1'b1;
                        target_r  <= TGT_CBT;
                        strobe_o  <= 1'b1;
                        str_cnt_r <= LD_DQS;
                        state_o   <= ST_FALL;
                     end
                     default: begin
                        ack_o <= 1'b1;
                        err_o <= 1'b1;
                     end
                  endcase
               end
            end

            ST_FALL: begin
               // CS is valid throughout the active state, well ahead
               if (cke_ok && ckel_cnt_r == CNT_ZERO &&
                   str_cnt_r == CNT_ZERO) begin
                  cke_o     <= 1'b0;
                  cke_cnt_r <= LD_CKE;
                  if (last_op_r == `OP_MRW) begin
                     hold_cnt_r <= LD_HMRW;
                  end else if (last_op_r == `OP_ZQ) begin
                     hold_cnt_r <= LD_HZQ;
                  end else begin
                     hold_cnt_r <= LD_HLD;
                  end
                  if (target_r == TGT_CBT) begin
                     gap_cnt_r <= LD_CAENT;
                  end
                  if (target_r == TGT_SR) begin
                     sr_cnt_r <= LD_SR;
                  end
                  state_o <= ST_HOLD;
               end
            end

            ST_HOLD: begin
               if (hold_cnt_r == CNT_ZERO) begin
                  if (target_r == TGT_CBT) begin
                     state_o <= ST_CBT;
                  end else begin
                     // Training needs the clock, so only here does it stop
                     ck_en_o    <= 1'b0;
                     cs_valid_o <= 1'b0;
                     state_o    <= ST_LOW;
                  end
               end
            end

            ST_LOW: begin
               if (take) begin
                  if ((req_op_i == `OP_PDX && target_r == TGT_PD) ||
                      (req_op_i == `OP_SRX && target_r == TGT_SR)) begin
                     // Stall, not refuse, until the low level may end
                     if (cke_ok && sr_cnt_r == CNT_ZERO) begin
                        ack_o      <= 1'b1;
                        ck_en_o    <= 1'b1;
                        cs_valid_o <= 1'b1;
                        pre_cnt_r  <= LD_WAKE;
                        state_o    <= ST_WAKE;
                     end
                  end else begin
                     ack_o <= 1'b1;
                     err_o <= 1'b1;
                  end
               end
            end

            ST_WAKE: begin
               // MRR waits exit delay, row delay and 3 more clocks
               if (pre_cnt_r == CNT_ZERO && cke_ok) begin
                  cke_o     <= 1'b1;
                  cke_cnt_r <= LD_CKE;
                  last_op_r <= `OP_CMD;
                  mrr_cnt_r <= LD_MRRI;
                  if (target_r == TGT_SR) begin
                     gap_cnt_r <= LD_XSR;
                  end else begin
                     gap_cnt_r <= LD_XP;
                  end
                  state_o <= ST_ACT;
               end
            end

            ST_CBT: begin
               // Training steps are spaced by their own settle times
               if (take) begin
                  case (req_op_i)
                     `OP_CBTC: begin
                        if (gap_ok) begin
                           ack_o       <= 1'b1;
                           cmd_valid_o <= 1'b1;
                           cmd_code_o  <= req_op_i;
                           gap_cnt_r   <= LD_CACD;
                        end
                     end

                     `OP_VREF: begin
                        if (gap_ok) begin
                           ack_o       <= 1'b1;
                           cmd_valid_o <= 1'b1;
                           cmd_code_o  <= req_op_i;
                           // Settling time depends on the step count
                           if (req_multi_i) begin
                              gap_cnt_r <= LD_VLG;
                           end else begin
                              gap_cnt_r <= LD_VSH;
                           end
                        end
                     end

                     `OP_CBTX: begin
                        ack_o     <= 1'b1;
                        pre_cnt_r <= LD_PRECS;
                        state_o   <= ST_CBTX;
                     end
                     default: begin
                        ack_o <= 1'b1;
                        err_o <= 1'b1;
                     end
                  endcase
               end
            end

            ST_CBTX: begin
               // Last training step must settle before the exit edge
               if (pre_cnt_r == CNT_ZERO && cke_ok && gap_ok) begin
                  cke_o     <= 1'b1;
                  strobe_o  <= 1'b0;
                  cke_cnt_r <= LD_CKE;
                  last_op_r <= `OP_CMD;
                  gap_cnt_r <= LD_PSTCS;
                  state_o   <= ST_ACT;
               end
            end

            // Unused codes fall back to the active state
            default: begin
               state_o <= ST_ACT;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: sim/lp_seq_monitor.sv */
/*
 Concurrent checks on the sequencer's pin outputs: clock-enable widths,
 clock and chip-select holds, and command spacing.
 Assumes one clock domain and the constants header on the include path.
*/
`default_nettype none
`include "lp_seq_consts.vh"
module lp_seq_monitor (
   input wire logic       mclk_i,
   input wire logic       rstn_i,
   input wire logic       cke_o,
   input wire logic       ck_en_o,
   input wire logic       cs_valid_o,
   input wire logic       strobe_o,
   input wire logic       cmd_valid_o,
   input wire logic [3:0] cmd_code_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       cke_q_r;
   logic [7:0] cke_age_r;
   // Age counts samples at the current level, saturating
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cke_q_r   <= 1'b1;
         cke_age_r <= 8'h00;
      end else begin
         cke_q_r <= cke_o;
         if (cke_o != cke_q_r) cke_age_r <= 8'h01;
         else if (cke_age_r != 8'hFF) cke_age_r <= cke_age_r + 8'h01;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   a_cke_min_width: assert property (
      cke_o != cke_q_r |-> cke_age_r >= 4)
      else $error("clock enable level held too briefly");
   a_cmd_before_low: assert property (
      cmd_valid_o |=> (!$fell(cke_o)) [*2])
      else $error("clock enable fell too soon after a command");
   a_clk_after_low: assert property (
      $fell(cke_o) |-> (ck_en_o && cs_valid_o) [*5])
      else $error("clock or select dropped too soon");
   a_clk_before_high: assert property ($rose(cke_o) |->
      $past(ck_en_o, 3) && $past(ck_en_o, 2) && $past(ck_en_o))
      else $error("clock not running before wake");
   a_cmd_after_exit: assert property (
      $rose(cke_o) |-> (!cmd_valid_o) [*5])
      else $error("command too soon after wake");
   a_cs_after_high: assert property ($rose(cke_o) |-> cs_valid_o [*5])
      else $error("select dropped after wake");
   a_mrr_gap: assert property (cmd_valid_o && cmd_code_o == `OP_MRR |=>
      (!(cmd_valid_o && cmd_code_o == `OP_MRR)) [*7])
      else $error("mode reads too close");
   a_mrw_gap: assert property (cmd_valid_o && cmd_code_o == `OP_MRW
      |=> (!cmd_valid_o) [*8] ##1 !cmd_valid_o)
      else $error("command too soon after mode write");
   a_cbt_first_cmd: assert property ($fell(cke_o) && strobe_o |->
      (!cmd_valid_o) [*8] ##1 (!cmd_valid_o) [*5])
      else $error("training command too soon");
   a_strobe_lead: assert property (
      $fell(cke_o) && strobe_o |-> $past(strobe_o))
      else $error("strobe not valid ahead of clock enable low");
endmodule
bind lp_cmd_sequencer lp_seq_monitor u_mon (.mclk_i, .rstn_i, .cke_o,
   .ck_en_o, .cs_valid_o, .strobe_o, .cmd_valid_o, .cmd_code_o);
`default_nettype wire

/* File: sim/dram_model.sv */
/*
 Behavioural low-power DRAM: tracks power state from the pins, answers
 training commands and counts commands that break its settle times.
 Assumes it is driven by the sequencer's pin outputs on mclk_i.
*/
`default_nettype none
`include "lp_seq_consts.vh"
module dram_model (
   input wire logic       mclk_i,
   input wire logic       rstn_i,
   input wire logic       cke_i,
   input wire logic       strobe_i,
   input wire logic       cmd_valid_i,
   input wire logic       multi_i,
   input wire logic [3:0] cmd_code_i,
   output logic           pd_o,
   output logic           sr_o,
   output logic           cbt_o,
   output logic           dq_valid_o,
   output logic     [7:0] viol_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sre_r;
   logic [3:0] settle_r;
   logic       bad;
   assign bad = cmd_valid_i && (pd_o || sr_o || (cbt_o &&
      cmd_code_i != `OP_CBTC && cmd_code_i != `OP_VREF) ||
      (cmd_code_i == `OP_CBTC && settle_r > 4'h1));
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {pd_o, sr_o, cbt_o, dq_valid_o, sre_r} <= 5'h00;
         settle_r <= 4'h0;
         viol_o   <= 8'h00;
      end else begin
         if (cke_i) begin
            {pd_o, sr_o, cbt_o, dq_valid_o} <= 4'h0;
         end else if (!(pd_o || sr_o || cbt_o)) begin
            sr_o  <= sre_r;
            cbt_o <= strobe_i && !sre_r;
            pd_o  <= !sre_r && !strobe_i;
            sre_r <= 1'b0;
         end
         if (cmd_valid_i && cmd_code_i == `OP_SRE) sre_r <= 1'b1;
         // Readback lands one clock after the command, inside 20 ns
         if (cmd_valid_i && cmd_code_i == `OP_CBTC) dq_valid_o <= 1'b1;
         if (cmd_valid_i && cmd_code_i == `OP_VREF)
            settle_r <= multi_i ? 4'(`C_VLONG) : 4'(`C_VSHORT);
         else if (settle_r != 4'h0) settle_r <= settle_r - 4'h1;
         if (bad) viol_o <= viol_o + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
/*
 Self-checking bench for the low-power command sequencer: mode spacing,
 power-down, self-refresh and command bus training sequences.
 Assumes the device model and checker files are compiled alongside.
*/
`default_nettype none
`include "lp_seq_consts.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RCD_PS = 18000;
   localparam int RFC_PS = 180000;
   localparam int XSR_C  = (RFC_PS + 7500 + 19999) / 20000;
   localparam int MRRI_C = 5 + (RCD_PS + 19999) / 20000 + 3;
   localparam logic [31:0] YES = 32'h0000_0001;
   logic       mclk_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic       req_i = 1'b0;
   logic [3:0] req_op_i = 4'h0;
   logic       req_multi_i = 1'b0;
   wire        ack_o, err_o, cke_o, ck_en_o, cs_valid_o, strobe_o;
   wire        cmd_valid_o, pd_s, sr_s, cbt_s, dq_s;
   wire  [3:0] cmd_code_o;
   wire  [2:0] state_o;
   wire  [7:0] viol;
   int         cyc = 0, t_cmd = 0, t_prev = 0, t_ack = 0;
   int         t_fall = 0, t_rise = 0, t_off = 0, t_strb = 0;
   int         error_cnt = 0, check_count = 0;
   logic       cke_q = 1'b1, cken_q = 1'b1, strb_q = 1'b0;

   lp_cmd_sequencer #(.T_RCD_PS(RCD_PS), .T_RFCAB_PS(RFC_PS)) DUT (
      .mclk_i, .rstn_i, .req_i, .req_op_i, .req_multi_i, .ack_o, .err_o,
      .cke_o, .ck_en_o, .cs_valid_o, .strobe_o, .cmd_valid_o, .cmd_code_o,
      .state_o);
   dram_model u_dev (.mclk_i, .rstn_i, .cke_i(cke_o), .strobe_i(strobe_o),
      .cmd_valid_i(cmd_valid_o), .multi_i(req_multi_i),
      .cmd_code_i(cmd_code_o), .pd_o(pd_s), .sr_o(sr_s), .cbt_o(cbt_s),
      .dq_valid_o(dq_s), .viol_o(viol));

   always #10 mclk_i = ~mclk_i;

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Event stamps taken mid-cycle, where registered outputs are settled
   always @(negedge mclk_i) begin
      cyc = cyc + 1;
      if (cmd_valid_o === 1'b1) begin
         t_prev = t_cmd;
         t_cmd = cyc;
      end
      if (ack_o === 1'b1) t_ack = cyc;
      if (cke_o !== cke_q && cke_o === 1'b0) t_fall = cyc;
      if (cke_o !== cke_q && cke_o === 1'b1) t_rise = cyc;
      if (ck_en_o !== cken_q && ck_en_o === 1'b0) t_off = cyc;
      if (strobe_o === 1'b1 && strb_q !== 1'b1) t_strb = cyc;
      cke_q = cke_o;
      cken_q = ck_en_o;
      strb_q = strobe_o;
      if (cyc > 5000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // Request held through the edge that samples ack high, then dropped
   task automatic do_req(input logic [3:0] op, input logic multi,
                         output logic e);
      @(negedge mclk_i);
      req_i = 1'b1;
      req_op_i = op;
      req_multi_i = multi;
      do @(negedge mclk_i); while (ack_o !== 1'b1);
      e = err_o;
      @(negedge mclk_i);
      req_i = 1'b0;
   endtask

   task automatic wait_state(input logic [2:0] s);
      do @(negedge mclk_i); while (state_o !== s);
      #1;
   endtask

   task automatic t_reset();
      check({cke_o, ck_en_o, cs_valid_o, strobe_o, ack_o, err_o,
         cmd_valid_o, state_o}, 32'h0000_0380, "reset levels");
      $display("Test reset levels done");
   endtask

   task automatic t_mode();
      logic e;
      do_req(`OP_MRW, 1'b0, e);
      do_req(`OP_MRW, 1'b0, e);
      check(32'(t_cmd - t_prev), 32'h0000_000A, "write spacing");
      do_req(`OP_MRR, 1'b0, e);
      check(32'(t_cmd - t_prev), 32'h0000_000A, "mode set delay");
      check({28'h0, cmd_code_o}, {28'h0, `OP_MRR}, "read code");
      do_req(`OP_MRR, 1'b0, e);
      check(32'(t_cmd - t_prev), 32'h0000_0008, "read spacing");
      $display("Test mode spacing done");
   endtask

   task automatic t_pd(input logic [3:0] prior, input int hold);
      logic e;
      do_req(prior, 1'b0, e);
      do_req(`OP_PDE, 1'b0, e);
      wait_state(3'h3);
      check(32'(t_fall - t_cmd >= 3), YES, "command to cke low");
      check(32'(t_off - t_fall), 32'(hold), "hold");
      check({31'h0, cs_valid_o}, 32'h0000_0000, "select still valid");
      check({31'h0, pd_s}, YES, "device not powered down");
      do_req(`OP_CMD, 1'b0, e);
      check({31'h0, e}, YES, "command taken while asleep");
      do_req(`OP_PDX, 1'b0, e);
      wait_state(3'h0);
      check(32'(t_rise - t_ack), 32'h0000_0003, "clock lead");
      do_req(`OP_MRR, 1'b0, e);
      check(32'(t_cmd - t_rise >= MRRI_C), YES, "read after exit");
      $display("Test power-down after op %0h done", prior);
   endtask

   task automatic t_sr();
      logic e;
      do_req(`OP_SRE, 1'b0, e);
      wait_state(3'h3);
      check(32'(t_fall - t_cmd >= 3), YES, "entry to cke low");
      check({31'h0, sr_s}, YES, "device not in self-refresh");
      do_req(`OP_PDX, 1'b0, e);
      check({31'h0, e}, YES, "wrong exit taken");
      do_req(`OP_SRX, 1'b0, e);
      wait_state(3'h0);
      check(32'(t_rise - t_fall >= 3), YES, "self-refresh too short");
      do_req(`OP_CMD, 1'b0, e);
      check(32'(t_cmd - t_rise >= XSR_C), YES, "exit to command");
      $display("Test self-refresh done");
   endtask

   task automatic t_cbt();
      logic e;
      do_req(`OP_CBTE, 1'b0, e);
      wait_state(3'h5);
      check(32'(t_fall - t_strb >= 1), YES, "strobe lead");
      check({31'h0, cbt_s}, YES, "device not training");
      do_req(`OP_CMD, 1'b0, e);
      check({31'h0, e}, YES, "plain command in training");
      do_req(`OP_CBTC, 1'b0, e);
      check(32'(t_cmd - t_fall >= 13), YES, "first training command");
      @(negedge mclk_i);
      check({31'h0, dq_s}, YES, "no training readback");
      for (int m = 0; m < 2; m++) begin
         do_req(`OP_VREF, m[0], e);
         do_req(`OP_CBTC, 1'b0, e);
         check(32'(t_cmd - t_prev >= (m ? 13 : 4)), YES, "settle");
      end
      do_req(`OP_CBTX, 1'b0, e);
      wait_state(3'h0);
      check(32'(t_rise - t_ack >= 7), YES, "clock before exit");
      do_req(`OP_CMD, 1'b0, e);
      check(32'(t_cmd - t_rise >= 5), YES, "command after exit");
      $display("Test command bus training done");
   endtask

   initial begin
      repeat (8) @(negedge mclk_i);
      rstn_i = 1'b1;
      t_reset();
      t_mode();
      t_pd(`OP_CMD, 5);
      t_pd(`OP_MRW, 10);
      t_pd(`OP_ZQ, 5);
      t_sr();
      t_cbt();
      check({24'h0, viol}, 32'h0000_0000, "device violations");
      close_out();
   end
endmodule
`default_nettype wire
